// file: design/uart_parity_pkg.sv
package uart_parity_pkg;

   // ==========================================================
   // Register map (index, byte address is four times the index)
   localparam logic [7:0]  IDX_STATUS   = 8'h20;
   localparam logic [7:0]  IDX_DATA     = 8'h21;
   localparam logic [7:0]  IDX_BAUD     = 8'h22;
   localparam logic [7:0]  IDX_CTRL1    = 8'h23;
   localparam logic [7:0]  IDX_CTRL2    = 8'h24;
   localparam logic [11:0] ADDR_STATUS  = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [11:0] ADDR_DATA    = {2'b00, IDX_DATA, 2'b00};
   localparam logic [11:0] ADDR_BAUD    = {2'b00, IDX_BAUD, 2'b00};
   localparam logic [11:0] ADDR_CTRL1   = {2'b00, IDX_CTRL1, 2'b00};
   localparam logic [11:0] ADDR_CTRL2   = {2'b00, IDX_CTRL2, 2'b00};

   // ==========================================================
   // Reset values
   localparam logic [7:0]  STATUS_RESET = 8'hC0;
   localparam logic [7:0]  CTRL1_RESET  = 8'h00;
   localparam logic [7:0]  CTRL2_RESET  = 8'h00;
   localparam logic [7:0]  BAUD_RESET   = 8'h00;

   // ==========================================================
   // Timing: 16 samples per bit, majority vote around the middle
   localparam logic [3:0]  VOTE_FIRST   = 4'h7;
   localparam logic [3:0]  VOTE_MID     = 4'h8;
   localparam logic [3:0]  VOTE_LAST    = 4'h9;
   localparam logic [3:0]  SUB_LAST     = 4'hF;
   localparam logic [3:0]  BITS_SHORT   = 4'hA;   // Start, 8 bits, stop
   localparam logic [3:0]  BITS_LONG    = 4'hB;   // Start, 9 bits, stop

   // ==========================================================
   // Field layouts
   typedef struct packed {
      logic tx_empty_flag;
      logic tx_done_flag;
      logic rx_full_flag;
      logic idle_flag;
      logic overrun_flag;
      logic noise_flag;
      logic framing_error_flag;
      logic parity_error_flag;
   } status_t;

   typedef struct packed {
      logic rx_ninth_bit;
      logic tx_ninth_bit;
      logic serial_power_down;
      logic word_nine;
      logic wake_by_address;
      logic parity_enable;
      logic parity_odd_select;
      logic parity_irq_en;
   } ctrl1_t;

   typedef struct packed {
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic rx_irq_en;
      logic idle_irq_en;
      logic tx_enable;
      logic rx_enable;
      logic rx_mute;
      logic send_break;
   } ctrl2_t;

   typedef struct packed {
      logic [1:0] prescale_sel;
      logic [2:0] tx_rate_sel;
      logic [2:0] rx_rate_sel;
   } baud_t;

   typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
   typedef enum logic {RX_IDLE, RX_BITS} rx_state_t;

endpackage

// file: design/uart_parity_status_control.sv
// Contract
// - Frame is start, 8/7+parity/9/8+parity data, stop per word length and parity enable.
// - Even parity gives even ones count over low data bits plus parity.
// - Odd select gives odd ones count over low data bits plus parity.
// - With parity on, parity bit replaces the written word's top bit.
// - Receiver checks parity, sets parity error, interrupts when parity irq enabled.
// - Address mark wake judges the top data bit, never the parity bit.
// - Enabled serial events wake from wait mode, never from halt mode.
// - Halt suspends transmit and receive, clears sample dividers, freezes other registers; bus answer, line synchroniser, request and wake flops still clock.
// - One shared request: flag and enable set, processor mask clear.
// - Tx empty sets on load into shifter; no reload until cleared.
// - Tx done sets at end of data, preamble or break frame.
// - Rx full sets when a word reaches the buffer; cleared by status then read.
// - Idle flag once per received word, never on a mute wake idle.
// - Word arriving with rx full sets overrun, keeps buffered word.
// - Noise flag set with the frame, no own interrupt, cleared by status then read.
// - Framing error without own interrupt; suppressed when overrun also happens.
// - Parity error cleared by status read then any data access.
// - Nine-bit mode stores ninth received bit, sends software ninth bit.
// - Power-down stops prescalers and output after byte in progress; a queued data, preamble or break frame still loads and is sent.
// - Wake method bit: zero idle line, one address mark.
// - Parity settings take effect after current byte; parity in top position.
// - Rx irq enable covers overrun and rx full; idle enable covers idle.
//
// Implementation choices: register access over APB and the register offsets.
module uart_parity_status_control
   import uart_parity_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxPin,
   output logic             txPin,
   input  wire logic        cpuIrqMask,
   input  wire logic        waitMode,
   input  wire logic        haltMode,
   output logic             irqRequest,
   output logic             wakeRequest
);

   // ==========================================================
   // State
   status_t     flags_reg;
   status_t     seen_reg;
   logic        seenValid_reg;
   ctrl1_t      ctrl1_reg;
   ctrl2_t      ctrl2_reg;
   baud_t       baud_reg;
   logic [7:0]  txHold_reg;
   logic [7:0]  rxBuf_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        irq_reg;
   logic        wake_reg;
   logic        txPin_reg;
   tx_state_t   txState_reg;
   logic [11:0] txShift_reg;
   logic [3:0]  txLeft_reg;
   logic [3:0]  txSub_reg;
   logic [10:0] txTick_reg;
   logic        tePrev_reg;
   logic        prePending_reg;
   rx_state_t   rxState_reg;
   logic [3:0]  rxSub_reg;
   logic [3:0]  rxIdx_reg;
   logic [8:0]  rxData_reg;
   logic [1:0]  votes_reg;
   logic        noiseAcc_reg;
   logic        rxNine_reg;
   logic        rxPce_reg;
   logic        rxOdd_reg;
   logic [10:0] rxTick_reg;
   logic [7:0]  idleCnt_reg;
   logic        idleArmed_reg;
   logic        rxMeta_reg;
   logic        rxLine_reg;

   // Prescaler times rate divisor, counted in clock cycles per sample
   function automatic logic [10:0] rateDiv(input logic [1:0] pre, input logic [2:0] rate);
      logic [10:0] base;
      base = 11'h001;
      unique case (pre)
         2'b00: base = 11'h001;
         2'b01: base = 11'h003;
         2'b10: base = 11'h004;
         2'b11: base = 11'h00D;
      endcase
      return base << rate;
   endfunction

   // ==========================================================
   // APB decode; side effects only at the completing edge
   wire setupPhase = psel & penable & ~pready_reg;
   wire accessDone = psel & penable & pready_reg;
   wire actOk      = accessDone & ~haltMode;
   wire hitStatus  = paddr == ADDR_STATUS;
   wire hitData    = paddr == ADDR_DATA;
   wire hitBaud    = paddr == ADDR_BAUD;
   wire hitCtrl1   = paddr == ADDR_CTRL1;
   wire hitCtrl2   = paddr == ADDR_CTRL2;
   wire hitAny     = hitStatus | hitData | hitBaud | hitCtrl1 | hitCtrl2;
   wire statusAcc  = actOk & hitStatus;
   wire dataRead   = actOk & hitData & ~pwrite;
   wire dataWrite  = actOk & hitData & pwrite;
   wire wrBaud     = actOk & hitBaud & pwrite;
   wire wrCtrl1    = actOk & hitCtrl1 & pwrite;
   wire wrCtrl2    = actOk & hitCtrl2 & pwrite;
   wire clrRead    = dataRead & seenValid_reg;
   wire clrWrite   = dataWrite & seenValid_reg;
   wire clrParity  = (dataRead | dataWrite) & seenValid_reg;
   wire [7:0] readByte = hitStatus ? flags_reg :
                         hitData   ? rxBuf_reg :
                         hitBaud   ? baud_reg  :
                         hitCtrl1  ? ctrl1_reg :
                         hitCtrl2  ? ctrl2_reg : 8'h00;

   // Bus slave answers with one wait state
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= setupPhase;
         pslverr_reg <= setupPhase & ~hitAny;
         if (setupPhase) begin
            prdata_reg <= {24'h00_0000, readByte};
         end
      end
   end

   // ==========================================================
   // Transmitter timing; stops in halt and when powered down idle
   wire [10:0] txDiv    = rateDiv(baud_reg.prescale_sel, baud_reg.tx_rate_sel);
   wire        txBusy   = txState_reg == TX_SEND;
   wire        txRun    = ~haltMode & (~ctrl1_reg.serial_power_down | txBusy);
   wire        txSample = txRun & (txTick_reg == txDiv - 11'h001);
   wire        txBitEnd = txSample & txBusy & (txSub_reg == SUB_LAST);
   wire        txFinish = txBitEnd & (txLeft_reg == 4'h1);

   // Frame build: parity computed at load so changes apply to the next byte
   wire       nineTx    = ctrl1_reg.word_nine;
   wire [3:0] txBits    = nineTx ? BITS_LONG : BITS_SHORT;
   wire       txParity  = (nineTx ? ^txHold_reg : ^txHold_reg[6:0])
                          ^ ctrl1_reg.parity_odd_select;
   wire       txTop9    = ctrl1_reg.parity_enable ? txParity : ctrl1_reg.tx_ninth_bit;
   wire       txTop8    = ctrl1_reg.parity_enable ? txParity : txHold_reg[7];
   wire [11:0] dataFrame = nineTx ? {2'b11, txTop9, txHold_reg, 1'b0}
                                  : {3'b111, txTop8, txHold_reg[6:0], 1'b0};
   wire       canLoad   = ~txBusy & ~haltMode & ctrl2_reg.tx_enable;
   wire       loadBreak = canLoad & ctrl2_reg.send_break;
   wire       loadPre   = canLoad & ~ctrl2_reg.send_break & prePending_reg;
   wire       loadData  = canLoad & ~ctrl2_reg.send_break & ~prePending_reg
                          & ~flags_reg.tx_empty_flag;
   wire       txLoad    = loadBreak | loadPre | loadData;
   wire [11:0] loadFrame = loadBreak ? 12'h000 : loadPre ? 12'hFFF : dataFrame;

   // Sample divider
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         txTick_reg <= 11'h000;
      end else if (txSample || !txRun) begin
         txTick_reg <= 11'h000;
      end else begin
         txTick_reg <= txTick_reg + 11'h001;
      end
   end

   // Shifter: break, then preamble, then data; LSB first
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         txState_reg <= TX_IDLE;
         txShift_reg <= 12'hFFF;
         txLeft_reg  <= 4'h0;
         txSub_reg   <= 4'h0;
      end else if (txLoad) begin
         txState_reg <= TX_SEND;
         txShift_reg <= loadFrame;
         txLeft_reg  <= txBits;
         txSub_reg   <= 4'h0;
      end else if (txSample && txBusy) begin
         txSub_reg <= txSub_reg + 4'h1;
         if (txBitEnd) begin
            txShift_reg <= {1'b1, txShift_reg[11:1]};
            txLeft_reg  <= txLeft_reg - 4'h1;
            if (txFinish) begin
               txState_reg <= TX_IDLE;
            end
         end
      end
   end

   // A rising transmit enable queues one preamble frame
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tePrev_reg     <= 1'b0;
         prePending_reg <= 1'b0;
         txPin_reg      <= 1'b1;
      end else if (!haltMode) begin
         tePrev_reg     <= ctrl2_reg.tx_enable;
         prePending_reg <= (ctrl2_reg.tx_enable & ~tePrev_reg) | (prePending_reg & ~loadPre);
         txPin_reg      <= txBusy ? txShift_reg[0] : 1'b1;
      end
   end

   // ==========================================================
   // Receiver: pin synchroniser, then 16x sampling with 3-sample vote
   wire [10:0] rxDiv    = rateDiv(baud_reg.prescale_sel, baud_reg.rx_rate_sel);
   wire        rxBusy   = rxState_reg == RX_BITS;
   wire        rxRun    = ~haltMode & ctrl2_reg.rx_enable
                          & (~ctrl1_reg.serial_power_down | rxBusy);
   wire        rxSample = rxRun & (rxTick_reg == rxDiv - 11'h001);
   wire        bitVal   = (votes_reg[0] & votes_reg[1]) | (votes_reg[0] & rxLine_reg)
                          | (votes_reg[1] & rxLine_reg);
   wire        bitNoisy = ~((votes_reg[0] == votes_reg[1]) & (votes_reg[1] == rxLine_reg));
   wire        atVote   = rxSample & rxBusy & (rxSub_reg == VOTE_LAST);
   wire [3:0]  lastIdx  = rxNine_reg ? BITS_LONG - 4'h1 : BITS_SHORT - 4'h1;
   wire        falseStart = atVote & (rxIdx_reg == 4'h0) & bitVal;
   wire        wordDone = atVote & (rxIdx_reg == lastIdx);
   wire        wordNoise = noiseAcc_reg | bitNoisy;
   wire        wordFrame = ~bitVal;
   wire        rxXor    = rxNine_reg ? ^rxData_reg : ^rxData_reg[7:0];
   wire        wordParBad = rxPce_reg & (rxXor != rxOdd_reg);
   wire        rxMsb    = rxNine_reg ? (rxPce_reg ? rxData_reg[7] : rxData_reg[8])
                                     : (rxPce_reg ? rxData_reg[6] : rxData_reg[7]);
   wire [3:0]  dataPos  = rxIdx_reg - 4'h1;
   wire [3:0]  txBitsRx = ctrl1_reg.word_nine ? BITS_LONG : BITS_SHORT;
   wire [7:0]  idleTarget = {txBitsRx, 4'h0};
   wire        idleEvent = rxSample & ~rxBusy & rxLine_reg & (idleCnt_reg == idleTarget - 8'h01);

   // Mute handling and word acceptance
   wire muted     = ctrl2_reg.rx_mute;
   wire addrWake  = wordDone & muted & ctrl1_reg.wake_by_address & rxMsb;
   wire idleWake  = idleEvent & muted & ~ctrl1_reg.wake_by_address;
   wire acceptWord = wordDone & (~muted | addrWake);
   wire setOverrun = acceptWord & flags_reg.rx_full_flag;
   wire setRxFull  = acceptWord & ~flags_reg.rx_full_flag;
   wire setIdle    = idleEvent & ~muted & idleArmed_reg;

   // Two-flop synchroniser on the line
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rxMeta_reg <= 1'b1;
         rxLine_reg <= 1'b1;
      end else begin
         rxMeta_reg <= rxPin;
         rxLine_reg <= rxMeta_reg;
      end
   end

   // Sample divider
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rxTick_reg <= 11'h000;
      end else if (rxSample || !rxRun) begin
         rxTick_reg <= 11'h000;
      end else begin
         rxTick_reg <= rxTick_reg + 11'h001;
      end
   end

   // Bit sequencer; format latched at the start edge so mid-word changes wait
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rxState_reg  <= RX_IDLE;
         rxSub_reg    <= 4'h0;
         rxIdx_reg    <= 4'h0;
         rxData_reg   <= 9'h000;
         votes_reg    <= 2'b11;
         noiseAcc_reg <= 1'b0;
         rxNine_reg   <= 1'b0;
         rxPce_reg    <= 1'b0;
         rxOdd_reg    <= 1'b0;
      end else if (!ctrl2_reg.rx_enable && !haltMode) begin
         rxState_reg <= RX_IDLE;
      end else if (rxSample) begin
         if (!rxBusy) begin
            if (!rxLine_reg) begin
               rxState_reg  <= RX_BITS;
               rxSub_reg    <= 4'h1;
               rxIdx_reg    <= 4'h0;
               noiseAcc_reg <= 1'b0;
               rxNine_reg   <= ctrl1_reg.word_nine;
               rxPce_reg    <= ctrl1_reg.parity_enable;
               rxOdd_reg    <= ctrl1_reg.parity_odd_select;
            end
         end else begin
            rxSub_reg <= rxSub_reg + 4'h1;
            if (rxSub_reg == VOTE_FIRST) begin
               votes_reg[0] <= rxLine_reg;
            end
            if (rxSub_reg == VOTE_MID) begin
               votes_reg[1] <= rxLine_reg;
            end
            if (atVote) begin
               noiseAcc_reg <= wordNoise;
               if (falseStart || wordDone) begin
                  rxState_reg <= RX_IDLE;
               end else if (rxIdx_reg != 4'h0) begin
                  rxData_reg[dataPos] <= bitVal;
               end
            end
            if (rxSub_reg == SUB_LAST) begin
               rxIdx_reg <= rxIdx_reg + 4'h1;
            end
         end
      end
   end

   // Idle line counter; fires once per idle stretch
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         idleCnt_reg   <= 8'h00;
         idleArmed_reg <= 1'b0;
      end else if (!haltMode) begin
         if (rxBusy || (rxSample && !rxLine_reg)) begin
            idleCnt_reg <= 8'h00;
         end else if (rxSample && idleCnt_reg != idleTarget) begin
            idleCnt_reg <= idleCnt_reg + 8'h01;
         end
         idleArmed_reg <= setRxFull | (idleArmed_reg & ~setIdle);
      end
   end

   // ==========================================================
   // Status flags: set wins over the clearing sequence
   status_t flags_next;
   assign flags_next.tx_empty_flag      = loadData | (flags_reg.tx_empty_flag
                                          & ~(clrWrite & seen_reg.tx_empty_flag));
   assign flags_next.tx_done_flag       = txFinish | (flags_reg.tx_done_flag
                                          & ~(clrWrite & seen_reg.tx_done_flag));
   assign flags_next.rx_full_flag       = setRxFull | (flags_reg.rx_full_flag
                                          & ~(clrRead & seen_reg.rx_full_flag));
   assign flags_next.idle_flag          = setIdle | (flags_reg.idle_flag
                                          & ~(clrRead & seen_reg.idle_flag));
   assign flags_next.overrun_flag       = setOverrun | (flags_reg.overrun_flag
                                          & ~(clrRead & seen_reg.overrun_flag));
   assign flags_next.noise_flag         = (setRxFull & wordNoise) | (flags_reg.noise_flag
                                          & ~(clrRead & seen_reg.noise_flag));
   assign flags_next.framing_error_flag = (setRxFull & wordFrame) | (flags_reg.framing_error_flag
                                          & ~(clrRead & seen_reg.framing_error_flag));
   assign flags_next.parity_error_flag  = (setRxFull & wordParBad) | (flags_reg.parity_error_flag
                                          & ~(clrParity & seen_reg.parity_error_flag));

   // Flags, status snapshot and receive buffer; all frozen in halt
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flags_reg     <= STATUS_RESET;
         seen_reg      <= 8'h00;
         seenValid_reg <= 1'b0;
         rxBuf_reg     <= 8'h00;
      end else if (!haltMode) begin
         flags_reg <= flags_next;
         if (statusAcc) begin
            seen_reg      <= flags_reg;
            seenValid_reg <= 1'b1;
         end else if (dataRead || dataWrite) begin
            seenValid_reg <= 1'b0;
         end
         if (setRxFull) begin
            rxBuf_reg <= rxData_reg[7:0];
         end
      end
   end

   // ==========================================================
   // Control registers; a software write to mute beats a wake in the same cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl1_reg  <= CTRL1_RESET;
         ctrl2_reg  <= CTRL2_RESET;
         baud_reg   <= BAUD_RESET;
         txHold_reg <= 8'h00;
      end else if (!haltMode) begin
         if (wrCtrl1) begin
            ctrl1_reg[6:0] <= pwdata[6:0];
         end
         if (setRxFull) begin
            ctrl1_reg.rx_ninth_bit <= rxData_reg[8];
         end
         if (wrCtrl2) begin
            ctrl2_reg <= pwdata[7:0];
         end else if (addrWake || idleWake) begin
            ctrl2_reg.rx_mute <= 1'b0;
         end
         if (wrBaud) begin
            baud_reg <= pwdata[7:0];
         end
         if (dataWrite) begin
            txHold_reg <= pwdata[7:0];
         end
      end
   end

   // ==========================================================
   // Shared request and wait-mode wake
   wire evtPending = (flags_reg.tx_empty_flag & ctrl2_reg.tx_empty_irq_en)
                   | (flags_reg.tx_done_flag & ctrl2_reg.tx_done_irq_en)
                   | ((flags_reg.rx_full_flag | flags_reg.overrun_flag) & ctrl2_reg.rx_irq_en)
                   | (flags_reg.idle_flag & ctrl2_reg.idle_irq_en)
                   | (flags_reg.parity_error_flag & ctrl1_reg.parity_irq_en);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_reg  <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         irq_reg  <= evtPending & ~cpuIrqMask;
         wake_reg <= evtPending & waitMode & ~haltMode;
      end
   end

   assign prdata      = prdata_reg;
   assign pready      = pready_reg;
   assign pslverr     = pslverr_reg;
   assign txPin       = txPin_reg;
   assign irqRequest  = irq_reg;
   assign wakeRequest = wake_reg;

endmodule

// file: testbench/test_uart_parity_status_control.sv
// ==================
// Serial block bench
module test_uart_parity_status_control import uart_parity_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, cpuIrqMask = 0, waitMode = 0, haltMode = 0;
   logic pready, pslverr, rxPin, txPin, irqRequest, wakeRequest;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rs = 32'h57, r;
   logic [8:0] e, readQ[$], frameQ[$];
   int fail_count = 0, tests_run = 0;
   uart_parity_status_control uut (.*);
   uart_far_end far (.clock, .txPin, .rxPin);
   // Clock
   initial forever #5 clock = ~clock;
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      fail_count += int'(seen !== exp);
      if (seen !== exp) $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
   endtask
   // One idle cycle after each transfer keeps psel from two writes in one step
   task automatic bus(input logic wr, input logic [11:0] a, input logic [8:0] v);
      if (!wr) readQ.push_back(v);
      {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, 23'h0, v};
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1);
      {psel, penable} <= 2'h0;
      @(posedge clock);
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Answers and far-end frames against the oldest note
   always @(posedge clock) if (psel && penable && pready === 1'h1 && !pwrite)
      check({pslverr, prdata[7:0]}, readQ.pop_front());
   always @(far.frames) check(far.word, frameQ.pop_front());
   // Watchdog
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clock);
      reset_n <= 1'h1;
      @(posedge clock);
      bus(1'h0, ADDR_STATUS, 9'h0C0);
      bus(1'h0, 12'hFFC, 9'h100);
      bus(1'h1, ADDR_CTRL2, 9'h02C);
      repeat (200) @(posedge clock);
      for (int c = 0; c < 8; c++) begin
         r = rnd();
         bus(1'h1, ADDR_CTRL1, {2'h0, r[8], 1'h0, c[2], 1'h0, c[1:0], 1'h0});
         e = c[2] ? {c[1] ? ^r[7:0] ^ c[0] : r[8], r[7:0]} : {1'h1, c[1] ? ^r[6:0] ^ c[0] : r[7], r[6:0]};
         frameQ.push_back(e);
         bus(1'h0, ADDR_STATUS, 9'h0C0);
         bus(1'h1, ADDR_DATA, {1'h0, r[7:0]});
         repeat (200) @(posedge clock);
      end
      bus(1'h1, ADDR_DATA, 9'h0A5);
      bus(1'h1, ADDR_CTRL1, 9'h004);
      far.send({2'h3, ~^r[6:0], r[6:0], 1'h0});
      check({8'h00, irqRequest}, 9'h001);
      {cpuIrqMask, waitMode} <= 2'h3;
      repeat (2) @(posedge clock);
      check({7'h00, irqRequest, wakeRequest}, 9'h001);
      haltMode <= 1'h1;
      bus(1'h1, ADDR_CTRL1, 9'h000);
      {cpuIrqMask, waitMode, haltMode} <= 3'h0;
      bus(1'h0, ADDR_CTRL1, 9'h004);
      bus(1'h0, ADDR_STATUS, 9'h0E1);
      bus(1'h0, ADDR_DATA, {1'h0, ~^r[6:0], r[6:0]});
      bus(1'h0, ADDR_STATUS, 9'h0C0);
      bus(1'h1, ADDR_CTRL1, 9'h000);
      far.send({2'h3, r[15:8], 1'h0});
      far.send({2'h2, r[23:16], 1'h0});
      bus(1'h0, ADDR_STATUS, 9'h0E8);
      bus(1'h0, ADDR_DATA, {1'h0, r[15:8]});
      summarize();
   end
endmodule

// file: testbench/uart_chk.sv
// ==========================================
// Port checks on bus answer, request and wake
module uart_chk (
   input wire logic clock, reset_n, penable, pready, pslverr,
   input wire logic cpuIrqMask, waitMode, haltMode, irqRequest, wakeRequest
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // One wait state and a one-cycle answer; requests lag their cause by one cycle
   chk_ready_once: assert property (pready |=> !pready) else $error("ready too long");
   chk_ready_wait: assert property ($rose(penable) |=> pready) else $error("ready late");
   chk_ready_need: assert property (!penable |=> !pready) else $error("ready unasked");
   chk_err_ready: assert property (pslverr |-> pready) else $error("lone error");
   chk_irq_mask: assert property (cpuIrqMask |=> !irqRequest) else $error("masked irq");
   chk_wake_wait: assert property (!waitMode |=> !wakeRequest) else $error("wake, no wait");
   chk_wake_halt: assert property (haltMode |=> !wakeRequest) else $error("wake in halt");
   chk_wake_irq: assert property (wakeRequest && !$past(cpuIrqMask) |-> irqRequest) else $error("wake, no irq");
   cover property (pslverr);
   cover property (irqRequest);
   cover property (wakeRequest);
endmodule
bind uart_parity_status_control uart_chk chk (.*);

// file: testbench/uart_far_end.sv
// =========================
// Far-end serial transceiver
module uart_far_end (input wire logic clock, txPin, output logic rxPin = 1'h1);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] word;
   int frames = 0;
   // Drive a frame LSB first, 16 clocks a bit
   task automatic send(input logic [10:0] f);
      for (int i = 0; i < 11; i++) repeat (16) @(posedge clock) rxPin <= f[i];
   endtask
   // Sample mid-bit; bit 8 is the stop bit of short words
   always @(negedge txPin) begin
      repeat (8) @(posedge clock);
      for (int i = 0; i < 9; i++) repeat (16) @(posedge clock) word[i] = txPin;
      frames++;
   end
endmodule
